/* logic/cpsc_top.sv */
// CPU processing-state controller with AXI4-Lite control registers
//
// Operation
// RULE1: init pin low aborts into reset
// RULE2: NMI high power-on, low manual reset
// RULE3: all interrupts masked while in reset
// RULE4: reset handling starts on synced init rise
// RULE5: watchdog overflow behaves like init pin
// RULE6: priority reset, trace, interrupt, trap
// RULE7: trap instruction always accepted in execution; dropped if bus_req is high at the same instruction end
// RULE8: interrupts taken only at boundaries
// RULE9: no interrupt after ccr/ldc or reset
// RULE10: interrupts incl. NMI off after reset handling
// RULE11: reset fetches vector then executes
// RULE12: trace only in interrupt control mode 2
// RULE13: trace flag traps every instruction end
// RULE14: trace end clears flag, masks untouched
// RULE15: no trace after return; restored flag
// RULE16: mode 0 never traces
// RULE17: push PC, push control, mask, vector
// RULE18: bus request releases bus, halts CPU
// RULE19: sleep with select 0 enters sleep
// RULE20: sleep with select 1 enters standby
// RULE21: standby pin low halts, resets modules
// RULE22: medium-speed divides clock; module stop
// RULE23: five distinct states, return from release
// RULE24: serve highest pending, keep others
//
// Register access over AXI4-Lite and the placing of the registers were decided locally.
`timescale 1ns/1ps
module cpsc_top
    import cpsc_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // AXI4-Lite write address and data
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Asynchronous pins
    input wire logic chip_init_pin_n,
    input wire logic nmi_pin,
    input wire logic hw_standby_pin_n,
    // Same-clock event sources
    input wire logic irq_req,
    input wire logic wdt_overflow,
    input wire logic bus_req,
    input wire cpsc_instr_t instr,
    // Outputs to core and chip
    output cpsc_state_t proc_state,
    output cpsc_seq_t seq,
    output logic bus_grant,
    output logic cpu_halt,
    output logic clock_halt,
    output logic module_reset,
    output logic irq_masked,
    output logic trace_flag,
    output logic cpu_step_en,
    output logic [15:0] module_stop
);

    // Pin synchronisers: meta stage read only by sync stage
    logic [2:0] pin_meta_reg;
    logic [2:0] pin_sync_reg;
    logic init_prev_reg; // Last synced init level, for edge detect
    logic init_s;
    logic nmi_s;
    logic hw_standby_pin_n_s;
    logic init_rise;

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            pin_meta_reg <= PIN_RST;
            pin_sync_reg <= PIN_RST;
            init_prev_reg <= 1'b0;
        end else begin
            pin_meta_reg <= {hw_standby_pin_n, nmi_pin, chip_init_pin_n};
            pin_sync_reg <= pin_meta_reg;
            init_prev_reg <= pin_sync_reg[PIN_INIT];
        end
    end

    assign init_s = pin_sync_reg[PIN_INIT];
    assign nmi_s = pin_sync_reg[PIN_NMI];
    assign hw_standby_pin_n_s = pin_sync_reg[PIN_HW_STANDBY_PIN_N];
    assign init_rise = init_s && !init_prev_reg; // [RULE4]

    // Control state
    cpsc_state_t state_reg;
    cpsc_exc_t kind_reg; // Exception being serviced
    cpsc_step_t step_reg; // Step within the sequence
    cpsc_pd_t pd_reg;
    logic por_reg; // Power-on (1) or manual (0) reset
    logic irq_block_reg; // Interrupts held off after reset handling
    logic trap_pend_reg; // Trap deferred behind a higher exception
    logic wdt_hit_reg; // Watchdog or standby-pin release requested a reset
    logic trace_reg;
    logic dss_reg;
    logic [1:0] icm_reg;
    logic med_reg;
    logic [15:0] mstop_reg;

    // AXI write side
    logic aw_free_reg;
    logic w_free_reg;
    logic [7:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic wr_fire;
    cpsc_ctrl_t ctrl_wr;

    // Write fires once both halves are held and no response waits
    assign wr_fire = !aw_free_reg && !w_free_reg && !bvalid_reg;
    assign ctrl_wr = cpsc_ctrl_t'(wdata_reg);

    // Boundary decisions
    logic trace_ok;
    logic irq_ok;
    logic irq_gate;
    logic is_trap;

    // Trace needs mode 2, the flag, and not a return
    assign trace_ok = trace_reg && (icm_reg == ICM_MODE2) && (instr.iclass != IC_RTE); // [RULE12] [RULE15] [RULE16]
    assign irq_ok = irq_req && !irq_block_reg; // [RULE10]
    // Flag-altering instructions hide interrupts for one boundary
    assign irq_gate = irq_ok && !(instr.iclass inside {IC_CCR_AND, IC_CCR_OR, IC_CCR_XOR, IC_CTRL_LOAD}); // [RULE9]
    assign is_trap = instr.iclass == IC_TRAP;

    // Main processing-state machine
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            state_reg <= ST_RESET;
            kind_reg <= EX_RESET;
            step_reg <= SQ_VECTOR;
            pd_reg <= PD_NONE;
            por_reg <= 1'b1;
            irq_block_reg <= 1'b1;
            trap_pend_reg <= 1'b0;
            wdt_hit_reg <= 1'b0;
        end else if (!init_s) begin
            // Pin low: drop everything
            state_reg <= ST_RESET; // [RULE1]
            por_reg <= nmi_s; // [RULE2]
            pd_reg <= PD_NONE;
            irq_block_reg <= 1'b1; // [RULE3]
            trap_pend_reg <= 1'b0;
        end else if (!hw_standby_pin_n_s) begin
            state_reg <= ST_PDOWN;
            pd_reg <= PD_HW_HW_STANDBY_PIN_N; // [RULE21]
        end else if (wdt_overflow) begin
            state_reg <= ST_RESET; // [RULE5]
            wdt_hit_reg <= 1'b1;
            pd_reg <= PD_NONE;
            irq_block_reg <= 1'b1;
            trap_pend_reg <= 1'b0;
        end else begin
            unique case (state_reg)
                ST_RESET: begin
                    irq_block_reg <= 1'b1; // [RULE3]
                    // Released pin or watchdog starts the vector fetch
                    if (init_rise || wdt_hit_reg) begin
                        state_reg <= ST_EXC; // [RULE4] [RULE5]
                        kind_reg <= EX_RESET;
                        step_reg <= SQ_VECTOR; // Reset pushes nothing [RULE11]
                        wdt_hit_reg <= 1'b0;
                    end
                end
                ST_EXC: begin
                    if (step_reg != SQ_VECTOR) begin
                        step_reg <= cpsc_step_t'(step_reg + 2'h1); // [RULE17]
                    end else if (kind_reg == EX_RESET) begin
                        // No interrupt check right after reset handling
                        state_reg <= ST_EXEC; // [RULE11] [RULE9]
                        irq_block_reg <= 1'b1; // [RULE10]
                    end else if (irq_ok) begin
                        kind_reg <= EX_IRQ; // [RULE8]
                        step_reg <= SQ_PUSH_PC;
                    end else if (trap_pend_reg) begin
                        kind_reg <= EX_TRAP; // [RULE24]
                        step_reg <= SQ_PUSH_PC;
                        trap_pend_reg <= 1'b0;
                    end else begin
                        state_reg <= ST_EXEC;
                    end
                end
                ST_EXEC: begin
                    if (bus_req) begin
                        state_reg <= ST_BUSREL; // [RULE18]
                    end else if (instr.done) begin
                        if (instr.iclass == IC_CTRL_LOAD) begin
                            irq_block_reg <= 1'b0; // Software has set its masks
                        end
                        // Highest one wins; a trap behind it waits
                        if (trace_ok || irq_gate) begin
                            state_reg <= ST_EXC; // [RULE6] [RULE24]
                            kind_reg <= trace_ok ? EX_TRACE : EX_IRQ; // [RULE13] [RULE8]
                            step_reg <= SQ_PUSH_PC;
                            trap_pend_reg <= is_trap;
                        end else if (is_trap) begin
                            state_reg <= ST_EXC; // [RULE7]
                            kind_reg <= EX_TRAP;
                            step_reg <= SQ_PUSH_PC;
                        end else if (instr.iclass == IC_SLEEP) begin
                            state_reg <= ST_PDOWN; // [RULE19] [RULE20]
                            pd_reg <= dss_reg ? PD_SW_HW_STANDBY_PIN_N : PD_SLEEP;
                        end
                    end
                end
                ST_BUSREL: begin
                    if (!bus_req) begin
                        state_reg <= ST_EXEC; // [RULE23]
                    end
                end
                ST_PDOWN: begin
                    // Standby pin release restarts through reset
                    if (pd_reg == PD_HW_HW_STANDBY_PIN_N) begin
                        state_reg <= ST_RESET;
                        wdt_hit_reg <= 1'b1;
                        pd_reg <= PD_NONE;
                    end else if (irq_ok) begin
                        state_reg <= ST_EXC;
                        kind_reg <= EX_IRQ;
                        step_reg <= SQ_PUSH_PC;
                        pd_reg <= PD_NONE;
                    end
                end
                default: begin
                    state_reg <= ST_RESET;
                end
            endcase
        end
    end

    // Trace flag: software write, return restore, hardware clear
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            trace_reg <= 1'b0;
        end else if (state_reg == ST_RESET) begin
            trace_reg <= 1'b0;
        end else if (wr_fire && awaddr_reg == OFS_CTRL && wstrb_reg[0]) begin
            trace_reg <= ctrl_wr.trace_flag; // Software write beats hardware clear and return restore; only the reset state overrides it
        end else if (state_reg == ST_EXC && kind_reg == EX_TRACE && step_reg == SQ_VECTOR) begin
            trace_reg <= 1'b0; // [RULE14]
        end else if (state_reg == ST_EXEC && instr.done && instr.iclass == IC_RTE) begin
            trace_reg <= instr.restored_trace; // [RULE15]
        end
    end

    // Software-owned control fields
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            dss_reg <= 1'b0;
            icm_reg <= ICM_MODE0;
            med_reg <= 1'b0;
            mstop_reg <= 16'h0000;
        end else if (wr_fire) begin
            if (awaddr_reg == OFS_CTRL && wstrb_reg[0]) begin
                dss_reg <= ctrl_wr.deep_sleep_select;
                icm_reg <= ctrl_wr.int_ctrl_mode;
                med_reg <= ctrl_wr.med_speed;
            end
            if (awaddr_reg == OFS_MSTOP) begin
                if (wstrb_reg[0]) begin
                    mstop_reg[7:0] <= wdata_reg[7:0];
                end
                if (wstrb_reg[1]) begin
                    mstop_reg[15:8] <= wdata_reg[15:8];
                end
            end
        end
    end

    // Medium-speed step divider; full rate when off
    logic [2:0] med_cnt_reg;
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            med_cnt_reg <= 3'h0;
            cpu_step_en <= 1'b1;
        end else if (!med_reg) begin
            med_cnt_reg <= 3'h0;
            cpu_step_en <= 1'b1;
        end else begin
            med_cnt_reg <= (med_cnt_reg == MED_DIV_LAST) ? 3'h0 : 3'(med_cnt_reg + 3'h1);
            cpu_step_en <= med_cnt_reg == MED_DIV_LAST; // [RULE22]
        end
    end

    // Registered outputs, one clock behind the state
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            seq <= '0;
            bus_grant <= 1'b0;
            cpu_halt <= 1'b1;
            clock_halt <= 1'b0;
            module_reset <= 1'b0;
            irq_masked <= 1'b1;
        end else begin
            seq.push_pc <= state_reg == ST_EXC && step_reg == SQ_PUSH_PC; // [RULE17]
            seq.push_cr <= state_reg == ST_EXC && step_reg == SQ_PUSH_CR;
            seq.mask_upd <= state_reg == ST_EXC && step_reg == SQ_MASK && kind_reg != EX_TRACE; // [RULE14]
            seq.vec_fetch <= state_reg == ST_EXC && step_reg == SQ_VECTOR; // [RULE11]
            seq.kind <= kind_reg;
            bus_grant <= state_reg == ST_BUSREL; // [RULE18]
            cpu_halt <= state_reg inside {ST_RESET, ST_BUSREL, ST_PDOWN}; // [RULE19]
            clock_halt <= pd_reg inside {PD_SW_HW_STANDBY_PIN_N, PD_HW_HW_STANDBY_PIN_N}; // [RULE20] [RULE21]
            module_reset <= pd_reg == PD_HW_HW_STANDBY_PIN_N; // [RULE21]
            irq_masked <= state_reg == ST_RESET || irq_block_reg; // [RULE3] [RULE10]
        end
    end

    assign proc_state = state_reg;
    assign trace_flag = trace_reg;
    assign module_stop = mstop_reg; // Never includes the CPU [RULE22]

    // AXI write channel handling
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            aw_free_reg <= 1'b1;
            w_free_reg <= 1'b1;
            awaddr_reg <= 8'h00;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
        end else begin
            if (aw_free_reg && s_axi_awvalid) begin
                aw_free_reg <= 1'b0;
                awaddr_reg <= s_axi_awaddr;
            end
            if (w_free_reg && s_axi_wvalid) begin
                w_free_reg <= 1'b0;
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end
            if (wr_fire) begin
                bvalid_reg <= 1'b1;
                bresp_reg <= (awaddr_reg inside {OFS_CTRL, OFS_MSTOP, OFS_STATUS}) ? RESP_OKAY : RESP_SLVERR;
            end
            // Both channels reopen only after the response is taken
            if (bvalid_reg && s_axi_bready) begin
                bvalid_reg <= 1'b0;
                aw_free_reg <= 1'b1;
                w_free_reg <= 1'b1;
            end
        end
    end

    assign s_axi_awready = aw_free_reg;
    assign s_axi_wready = w_free_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;

    // Read data mux
    cpsc_status_t status;
    logic [31:0] rd_mux;
    logic rd_hit;
    always_comb begin
        status = '0;
        status.state = state_reg;
        status.pd = pd_reg;
        status.power_on = por_reg;
        status.irq_block = irq_block_reg;
        status.kind = kind_reg;
        status.trap_pend = trap_pend_reg;
        status.bus_grant = state_reg == ST_BUSREL;
        rd_hit = 1'b1;
        unique case (s_axi_araddr)
            OFS_CTRL: rd_mux = {27'h000_0000, med_reg, trace_reg, icm_reg, dss_reg};
            OFS_MSTOP: rd_mux = {16'h0000, mstop_reg};
            OFS_STATUS: rd_mux = 32'(status);
            default: begin
                rd_mux = 32'h0000_0000;
                rd_hit = 1'b0;
            end
        endcase
    end

    // AXI read channel: one outstanding read
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arready && s_axi_arvalid) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // Checks
    sequence push_steps;
        seq.push_pc ##1 seq.push_cr ##1 (seq.mask_upd || seq.kind == EX_TRACE) ##1 seq.vec_fetch;
    endsequence

    sequence steady_run;
        init_s && hw_standby_pin_n_s && !wdt_overflow;
    endsequence

    a_init_low_reset: assert property (@(posedge ref_clk) disable iff (reset) // [RULE1]
        !init_s |=> state_reg == ST_RESET) else $error("init low did not reset");
    a_reset_kind_sel: assert property (@(posedge ref_clk) disable iff (reset) // [RULE2]
        !init_s |=> por_reg == $past(nmi_s)) else $error("reset kind wrong");
    a_reset_masks_irq: assert property (@(posedge ref_clk) disable iff (reset) // [RULE3]
        state_reg == ST_RESET |=> irq_masked) else $error("irq unmasked in reset");
    a_rise_starts_exc: assert property (@(posedge ref_clk) disable iff (reset) // [RULE4]
        (state_reg == ST_RESET && init_rise) and steady_run |=> state_reg == ST_EXC && kind_reg == EX_RESET)
        else $error("init rise did not start reset handling");
    a_wdt_to_reset: assert property (@(posedge ref_clk) disable iff (reset) // [RULE5]
        (init_s && hw_standby_pin_n_s && wdt_overflow) |=> state_reg == ST_RESET && wdt_hit_reg)
        else $error("watchdog did not reset");
    a_trace_outranks: assert property (@(posedge ref_clk) disable iff (reset) // [RULE6]
        (state_reg == ST_EXEC && instr.done && trace_ok && !bus_req) and steady_run |=> kind_reg == EX_TRACE)
        else $error("trace lost priority");
    a_ccr_hides_irq: assert property (@(posedge ref_clk) disable iff (reset) // [RULE9]
        state_reg == ST_EXEC && instr.done && instr.iclass == IC_CCR_OR && !trace_ok |=> state_reg != ST_EXC)
        else $error("irq taken after ccr instruction");
    a_reset_ends_exec: assert property (@(posedge ref_clk) disable iff (reset) // [RULE10]
        (state_reg == ST_EXC && kind_reg == EX_RESET && step_reg == SQ_VECTOR) and steady_run
        |=> state_reg == ST_EXEC && irq_block_reg) else $error("reset handling did not end blocked");
    a_mode0_no_trace: assert property (@(posedge ref_clk) disable iff (reset) // [RULE16]
        icm_reg == ICM_MODE0 |-> !trace_ok) else $error("trace in mode 0");
    a_trace_clears: assert property (@(posedge ref_clk) disable iff (reset) // [RULE14]
        (state_reg == ST_EXC && kind_reg == EX_TRACE && step_reg == SQ_VECTOR && !wr_fire) and steady_run
        |=> !trace_reg) else $error("trace flag not cleared");
    a_push_order: assert property (@(posedge ref_clk) disable iff (reset || !init_s || !hw_standby_pin_n_s || wdt_overflow) // [RULE17]
        $rose(seq.push_pc) |-> push_steps) else $error("push order broken");
    a_bus_release: assert property (@(posedge ref_clk) disable iff (reset) // [RULE18]
        (state_reg == ST_EXEC && bus_req) and steady_run |=> state_reg == ST_BUSREL ##1 bus_grant && cpu_halt)
        else $error("bus not released");
    a_sleep_entry: assert property (@(posedge ref_clk) disable iff (reset) // [RULE19]
        (state_reg == ST_EXEC && instr.done && instr.iclass == IC_SLEEP && !dss_reg && !trace_ok && !irq_gate
        && !bus_req) and steady_run |=> pd_reg == PD_SLEEP ##1 cpu_halt && !clock_halt)
        else $error("sleep not entered");

endmodule // cpsc_top

/* logic/cpsc_pkg.sv */
// Shared types and constants for the CPU processing-state controller
package cpsc_pkg;

    // Main processing states
    typedef enum logic [2:0] {
        ST_RESET  = 3'b000,
        ST_EXC    = 3'b001,
        ST_EXEC   = 3'b010,
        ST_BUSREL = 3'b011,
        ST_PDOWN  = 3'b100
    } cpsc_state_t;

    // Exception kinds, highest priority first
    typedef enum logic [1:0] {
        EX_RESET = 2'b00,
        EX_TRACE = 2'b01,
        EX_IRQ   = 2'b10,
        EX_TRAP  = 2'b11
    } cpsc_exc_t;

    // Class of the instruction that just ended
    typedef enum logic [2:0] {
        IC_PLAIN     = 3'b000,
        IC_CCR_AND   = 3'b001,
        IC_CCR_OR    = 3'b010,
        IC_CCR_XOR   = 3'b011,
        IC_CTRL_LOAD = 3'b100,
        IC_RTE       = 3'b101,
        IC_SLEEP     = 3'b110,
        IC_TRAP      = 3'b111
    } cpsc_iclass_t;

    // Power-down flavours
    typedef enum logic [1:0] {
        PD_NONE    = 2'b00,
        PD_SLEEP   = 2'b01,
        PD_SW_HW_STANDBY_PIN_N = 2'b10,
        PD_HW_HW_STANDBY_PIN_N = 2'b11
    } cpsc_pd_t;

    // Steps of an exception sequence
    typedef enum logic [1:0] {
        SQ_PUSH_PC = 2'b00,
        SQ_PUSH_CR = 2'b01,
        SQ_MASK    = 2'b10,
        SQ_VECTOR  = 2'b11
    } cpsc_step_t;

    // Instruction-boundary report from the core
    typedef struct packed {
        logic done;
        cpsc_iclass_t iclass;
        logic restored_trace;
    } cpsc_instr_t;

    // Exception-sequence strobes to the core
    typedef struct packed {
        logic push_pc;
        logic push_cr;
        logic mask_upd;
        logic vec_fetch;
        cpsc_exc_t kind;
    } cpsc_seq_t;

    // Control register layout
    typedef struct packed {
        logic [26:0] rsvd;
        logic med_speed;
        logic trace_flag;
        logic [1:0] int_ctrl_mode;
        logic deep_sleep_select;
    } cpsc_ctrl_t;

    // Status register layout
    typedef struct packed {
        logic [19:0] rsvd;
        logic bus_grant;
        logic trap_pend;
        cpsc_exc_t kind;
        logic irq_block;
        logic power_on;
        cpsc_pd_t pd;
        logic pad;
        cpsc_state_t state;
    } cpsc_status_t;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_MSTOP = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;

    // Interrupt control modes
    localparam logic [1:0] ICM_MODE0 = 2'h0;
    localparam logic [1:0] ICM_MODE2 = 2'h2;

    // Medium-speed divider: CPU steps once per eight clocks
    localparam logic [2:0] MED_DIV_LAST = 3'h7;

    // Pin synchroniser lanes
    localparam int PIN_INIT = 0;
    localparam int PIN_NMI = 1;
    localparam int PIN_HW_STANDBY_PIN_N = 2;
    // Init lane resets low so release runs reset handling; NMI and standby lanes reset to their idle high
    localparam logic [2:0] PIN_RST = 3'h6;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

/* dv/cpsc_partner.sv */
// Other bus master: asks for the bus and keeps it a few cycles once granted
`timescale 1ns/1ps
module cpsc_partner (
    // Clock and trigger
    input wire logic ref_clk,
    input wire logic go,
    // Bus handshake
    input wire logic bus_grant,
    output logic bus_req
);
    logic [2:0] hold_reg = 3'h0; // Cycles held after grant
    initial bus_req = 1'b0;
    // Request stays up until the grant has stood five cycles
    always @(posedge ref_clk) begin
        if (go) begin
            bus_req <= 1'b1;
            hold_reg <= 3'h0;
        end else if (bus_req && bus_grant) begin
            hold_reg <= hold_reg + 3'h1;
            if (hold_reg == 3'h4) bus_req <= 1'b0;
        end
    end
endmodule // cpsc_partner

/* dv/tb_cpsc_top.sv */
// Self-checking bench for the processing-state controller
`timescale 1ns/1ps
module tb_cpsc_top;
    import cpsc_pkg::*;
    logic ref_clk = 0, reset = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, go = 0;
    logic init_n = 1, nmi = 1, irq = 0, wdt = 0, awready, wready, bvalid, arready, rvalid, bus_req, bus_grant;
    logic cpu_halt, irq_masked, trace_flag, mod_rst, hw_standby_pin_n_n = 1;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, d, seed = 32'h0000_0010;
    logic [1:0] bresp, rresp, r;
    cpsc_instr_t instr = '0;
    cpsc_state_t proc_state;
    cpsc_seq_t seq;
    int err_total = 0, comparisons = 0;
    // Xorshift source, fixed start so runs repeat
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Only the low half of module stop is kept
    function automatic logic [31:0] mstop_exp(logic [31:0] v);
        return {16'h0000, v[15:0]};
    endfunction
    task automatic chk(logic [31:0] got, logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic conclude();
        $display("errors %0d comparisons %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // Write: address and data offered together, each dropped when taken
    task automatic wr(logic [7:0] a, logic [31:0] v);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        do begin
            @(posedge ref_clk);
            if (awready && awvalid) awvalid <= 0;
            if (wready && wvalid) wvalid <= 0;
        end while (!bvalid);
        r = bresp;
    endtask
    task automatic rd(logic [7:0] a);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        do begin
            @(posedge ref_clk);
            if (arready && arvalid) arvalid <= 0;
        end while (!rvalid);
        d = rdata;
        r = rresp;
    endtask
    // Bounded wait for a state, then compare it
    task automatic wt(cpsc_state_t s);
        for (int i = 0; i < 60 && proc_state !== s; i++) @(posedge ref_clk);
        chk(proc_state, s);
    endtask
    task automatic step(cpsc_iclass_t c);
        instr <= '{1'b1, c, 1'b0};
        @(posedge ref_clk);
        instr <= '0;
        for (int i = 0; i < 9 && !seq.push_pc; i++) @(posedge ref_clk);
    endtask
    cpsc_top i_cpsc_top (.ref_clk(ref_clk), .reset(reset), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .chip_init_pin_n(init_n),
        .nmi_pin(nmi), .hw_standby_pin_n(hw_standby_pin_n_n), .irq_req(irq), .wdt_overflow(wdt), .bus_req(bus_req),
        .instr(instr), .proc_state(proc_state), .seq(seq), .bus_grant(bus_grant), .cpu_halt(cpu_halt),
        .clock_halt(), .module_reset(mod_rst), .irq_masked(irq_masked), .trace_flag(trace_flag),
        .cpu_step_en(), .module_stop());
    cpsc_partner i_cpsc_partner (.ref_clk(ref_clk), .go(go), .bus_grant(bus_grant), .bus_req(bus_req));
    initial forever #5 ref_clk = ~ref_clk;
    // Hang guard
    initial begin
        #200000;
        err_total++;
        conclude();
    end
    // Main sequence
    initial begin
        repeat (5) @(posedge ref_clk);
        reset <= 0;
        wt(ST_EXEC);
        chk(irq_masked, 1);
        d = rnd();
        wr(OFS_MSTOP, d);
        rd(OFS_MSTOP);
        chk(d, mstop_exp(seed));
        rd(8'h40);
        chk(d, 32'h0000_0000);
        chk(r, RESP_SLVERR);
        step(IC_TRAP);
        chk(seq, {4'b1000, EX_TRAP});
        @(posedge ref_clk);
        chk(seq.push_cr, 1);
        @(posedge ref_clk);
        chk(seq.mask_upd, 1);
        wt(ST_EXEC);
        wr(OFS_CTRL, 32'h0000_000C);
        step(IC_PLAIN);
        chk(seq.kind, EX_TRACE);
        wt(ST_EXEC);
        chk(trace_flag, 0);
        wr(OFS_CTRL, 32'h0000_0008);
        step(IC_PLAIN);
        chk(seq.push_pc, 0);
        go <= 1;
        @(posedge ref_clk);
        go <= 0;
        wt(ST_BUSREL);
        wt(ST_EXEC);
        irq <= 1;
        step(IC_CTRL_LOAD);
        step(IC_CTRL_LOAD);
        chk(seq.push_pc, 0);
        step(IC_PLAIN);
        chk(seq.kind, EX_IRQ);
        irq <= 0;
        wt(ST_EXEC);
        step(IC_SLEEP);
        chk(proc_state, ST_PDOWN);
        irq <= 1;
        wt(ST_EXC);
        irq <= 0;
        wt(ST_EXEC);
        init_n <= 0;
        wt(ST_RESET);
        @(posedge ref_clk);
        chk(irq_masked, 1);
        init_n <= 1;
        wt(ST_EXEC);
        hw_standby_pin_n_n <= 0;
        wt(ST_PDOWN);
        @(posedge ref_clk);
        chk(mod_rst, 1);
        hw_standby_pin_n_n <= 1;
        wt(ST_EXEC);
        wdt <= 1;
        @(posedge ref_clk);
        wdt <= 0;
        wt(ST_RESET);
        wt(ST_EXEC);
        conclude();
    end
endmodule // tb_cpsc_top
